// ==== logic/mup_pkg.sv ====
package mup_pkg;

  // relative port numbers inside the eight-port block
  localparam logic [2:0] PORT_CHAN_DATA   = 3'h0;
  localparam logic [2:0] PORT_CHAN_STATUS = 3'h1;
  localparam logic [2:0] PORT_MODE_PDATA  = 3'h2;
  localparam logic [2:0] PORT_CMD_PSTAT   = 3'h3;
  localparam logic [2:0] PORT_TX_IRQ      = 3'h4;
  localparam logic [2:0] PORT_RX_IRQ      = 3'h5;
  localparam logic [2:0] PORT_UNUSED      = 3'h6;
  localparam logic [2:0] PORT_USER_SEL    = 3'h7;

  // address layout: base in bits 7:3, relative port in bits 2:0
  localparam int ADDR_W      = 8;
  localparam int BASE_LSB    = 3;
  localparam int BASE_W      = 5;
  localparam int DATA_W      = 8;
  localparam int NIB_W       = 4;

  // user select register fields
  localparam int USEL_W      = 5;
  localparam int USEL_REL_LSB = 0;
  localparam int USEL_UL_BIT  = 2;
  localparam int USEL_BS_LSB  = 3;

  localparam logic [USEL_W-1:0] USEL_RESET = 5'h00;
  localparam logic [NIB_W-1:0]  MASK_RESET = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;

  // physical channel numbers
  localparam logic [1:0] CH_PARALLEL = 2'h0;
  localparam logic [1:0] CH_SWAPPED  = 2'h2;

  // one bus wait state, in ns, and the core clock rate
  localparam int T_WAIT_STATE_NS = 100;
  localparam int CORE_CLK_MHZ    = 200;
  localparam int WAIT_CYC = (T_WAIT_STATE_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int WCNT_W   = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_HOLD = 3'b100
  } mup_state_type;

endpackage

// ==== logic/mup_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module mup_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  initial
  begin
    if (WIDTH < 1)
      $error("mup_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit only moves once stages two and three agree
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      sync_o <= '0;
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_ff[i] == s3_ff[i])
          sync_o[i] <= s3_ff[i];
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/mup_port_decoder.sv ====
// What this block does
// - answers one block of eight ports
// - base is a multiple of eight
// - five switches compare address bits 7:3
// - five-bit user select picks among 32
// - selected user's registers mapped into ports
// - group of eight reaches interrupt registers
// - port 0 is data, also switch data
// - port 1 status read, sync/control write
// - port 2 mode or parallel data
// - port 3 command or parallel status
// - port 4 transmit status / mask
// - port 5 receive status / mask; 6 unused
// - eight requests, jumper-routed to lines
// - interrupt lines driven open collector
// - masks gate requests, status stays readable
// - jumpers insert one, two, three waits
// - swap puts parallel at relative 0 or 2
// - user select is write-only port 7
// - ports 0-5 respond only when select bits match switches
// - no waits on select or interrupt ports
`timescale 1ns/1ps
`default_nettype none
module mup_port_decoder
  import mup_pkg::*;
#(
  parameter int NUM_USERS = 4,
  parameter int NUM_LINES = 8
)
(
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic [ADDR_W-1:0]          bus_addr_i,
  input  wire logic [DATA_W-1:0]          bus_wdata_i,
  input  wire logic                       bus_rd_i,
  input  wire logic                       bus_wr_i,
  input  wire logic [BASE_W-1:0]          base_switch_i,
  input  wire logic                       board_select_low_switch_i,
  input  wire logic                       board_select_high_switch_i,
  input  wire logic                       upper_lower_switch_i,
  input  wire logic                       board_disable_switch_i,
  input  wire logic                       one_wait_jumper_i,
  input  wire logic                       two_wait_jumper_i,
  input  wire logic                       three_wait_jumper_i,
  input  wire logic                       channel_swap_jumper_i,
  input  wire logic [DATA_W-1:0]          config_switch_i,
  input  wire logic [2*NUM_USERS*NUM_LINES-1:0] irq_route_i,
  input  wire logic [NUM_USERS-1:0]       tx_req_i,
  input  wire logic [NUM_USERS-1:0]       rx_req_i,
  input  wire logic [DATA_W-1:0]          chan_rdata_i,
  output logic      [DATA_W-1:0]          bus_rdata_o,
  output logic      [1:0]                 bus_rdata_oe_o,
  output logic                            bus_rdy_o,
  output logic                            bus_rdy_oe_o,
  output logic      [NUM_LINES-1:0]       vi_o,
  output logic      [NUM_LINES-1:0]       vi_oe_o,
  output logic      [NUM_USERS-1:0]       chan_sel_o,
  output logic      [1:0]                 chan_reg_o,
  output logic                            chan_rd_o,
  output logic                            chan_wr_o,
  output logic      [DATA_W-1:0]          chan_wdata_o,
  output logic      [USEL_W-1:0]          user_select_o
);

  localparam int NREQ   = 2 * NUM_USERS;
  localparam int ROUTE_W = NREQ * NUM_LINES;
  localparam int SYNC_W = ADDR_W + DATA_W + 2 + BASE_W + 4 + 3 + 1 + DATA_W + ROUTE_W;

  initial
  begin
    if (NUM_USERS != NIB_W)
      $error("mup_port_decoder: NUM_USERS must equal the status nibble width");
    if (NUM_LINES < 1)
      $error("mup_port_decoder: NUM_LINES must be at least 1");
    if (3 * WAIT_CYC >= (1 << WCNT_W))
      $error("mup_port_decoder: wait count does not fit the counter");
  end

  // every pin-side input passes the three-flop filter
  logic [SYNC_W-1:0] sync_q;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] wdata_s;
  logic              rd_s;
  logic              wr_s;
  logic [BASE_W-1:0] base_s;
  logic              bs_lo_s;
  logic              bs_hi_s;
  logic              ul_s;
  logic              dis_s;
  logic              w1_s;
  logic              w2_s;
  logic              w3_s;
  logic              swap_s;
  logic [DATA_W-1:0] cfg_s;
  logic [ROUTE_W-1:0] route_s;

  mup_sync #(.WIDTH(SYNC_W)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({bus_addr_i, bus_wdata_i, bus_rd_i, bus_wr_i, base_switch_i,
                  board_select_low_switch_i, board_select_high_switch_i,
                  upper_lower_switch_i, board_disable_switch_i,
                  one_wait_jumper_i, two_wait_jumper_i, three_wait_jumper_i,
                  channel_swap_jumper_i, config_switch_i, irq_route_i}),
    .sync_o     (sync_q)
  );

  assign {addr_s, wdata_s, rd_s, wr_s, base_s, bs_lo_s, bs_hi_s, ul_s, dis_s,
          w1_s, w2_s, w3_s, swap_s, cfg_s, route_s} = sync_q;

  mup_state_type      state_ff;
  logic               strobe_prev_ff;
  logic [USEL_W-1:0]  usel_ff;
  logic [NIB_W-1:0]   tx_mask_ff;
  logic [NIB_W-1:0]   rx_mask_ff;
  logic [WCNT_W-1:0]  wcnt_ff;
  logic               cap_rd_ff;
  logic               cap_sw_ff;

  // decode of the access now starting
  logic              strobe_rise;
  logic              block_hit;
  logic [2:0]        rel_port;
  logic              board_hit;
  logic              group_hit;
  logic [1:0]        rel_user;
  logic [1:0]        phys_chan;
  logic              chan_access;
  logic              irq_access;
  logic              sel_access;
  logic [WCNT_W-1:0] wait_total;
  logic [NIB_W-1:0]  status_nib;
  logic [DATA_W-1:0] nib_placed;
  logic [1:0]        nib_oe;

  assign strobe_rise = (rd_s | wr_s) & ~strobe_prev_ff;
  assign rel_port    = addr_s[BASE_LSB-1:0];
  assign block_hit   = ~dis_s && (addr_s[ADDR_W-1:BASE_LSB] == base_s);
  assign board_hit   = (usel_ff[USEL_W-1:USEL_BS_LSB] == {bs_hi_s, bs_lo_s}) &&
                       (usel_ff[USEL_UL_BIT] == ul_s);
  assign group_hit   = (usel_ff[USEL_W-1:USEL_BS_LSB] == {bs_hi_s, bs_lo_s});
  assign rel_user    = usel_ff[USEL_REL_LSB+1:USEL_REL_LSB];
  // swap exchanges relative users 0 and 2
  assign phys_chan   = (swap_s && (rel_user == CH_PARALLEL)) ? CH_SWAPPED :
                       (swap_s && (rel_user == CH_SWAPPED))  ? CH_PARALLEL : rel_user;
  assign chan_access = board_hit && (rel_port <= PORT_CMD_PSTAT);
  assign irq_access  = group_hit && ((rel_port == PORT_TX_IRQ) || (rel_port == PORT_RX_IRQ));
  assign sel_access  = wr_s && (rel_port == PORT_USER_SEL);

  // jumpers give 1, 2 or 3 bus wait states; highest fitted wins
  always_comb
  begin
    if (w3_s)
      wait_total = WCNT_W'(3 * WAIT_CYC);
    else if (w2_s)
      wait_total = WCNT_W'(2 * WAIT_CYC);
    else if (w1_s)
      wait_total = WCNT_W'(WAIT_CYC);
    else
      wait_total = '0;
  end

  // pending status per relative user, swap applied, never masked
  always_comb
  begin
    status_nib = '0;
    for (int u = 0; u < NUM_USERS; u++)
    begin
      if (rel_port == PORT_TX_IRQ)
        status_nib[u] = tx_req_i[u];
      else
        status_nib[u] = rx_req_i[u];
    end
    if (swap_s)
      {status_nib[CH_PARALLEL], status_nib[CH_SWAPPED]} =
        {status_nib[CH_SWAPPED], status_nib[CH_PARALLEL]};
  end

  // upper-half board answers on D7-D4, lower-half on D3-D0
  assign nib_placed = ul_s ? {status_nib, 4'h0} : {4'h0, status_nib};
  assign nib_oe     = ul_s ? 2'b10 : 2'b01;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      strobe_prev_ff <= 1'b0;
    else
      strobe_prev_ff <= rd_s | wr_s;
  end

  // access sequencer; the host strobe level ends each access
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_ff  <= ST_IDLE;
      wcnt_ff   <= '0;
      cap_rd_ff <= 1'b0;
      cap_sw_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (strobe_rise && block_hit)
          begin
            if (chan_access)
            begin
              state_ff  <= ST_WAIT;
              wcnt_ff   <= wait_total;
              cap_rd_ff <= rd_s;
              cap_sw_ff <= rd_s && (rel_port == PORT_CHAN_DATA) &&
                           (phys_chan == CH_PARALLEL);
            end
            else
              state_ff <= ST_HOLD;
          end
        end
        ST_WAIT:
        begin
          if (wcnt_ff == '0)
            state_ff <= ST_HOLD;
          else
            wcnt_ff <= wcnt_ff - WCNT_W'(1);
        end
        ST_HOLD:
        begin
          if (!rd_s && !wr_s)
          begin
            state_ff  <= ST_IDLE;
            cap_rd_ff <= 1'b0;
            cap_sw_ff <= 1'b0;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      usel_ff <= USEL_RESET;
    else if ((state_ff == ST_IDLE) && strobe_rise && block_hit && sel_access)
      usel_ff <= wdata_s[USEL_W-1:0];
  end

  // masks: a set bit lets that request through
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_mask_ff <= MASK_RESET;
      rx_mask_ff <= MASK_RESET;
    end
    else if ((state_ff == ST_IDLE) && strobe_rise && block_hit && irq_access && wr_s)
    begin
      if (rel_port == PORT_TX_IRQ)
        tx_mask_ff <= ul_s ? wdata_s[DATA_W-1:NIB_W] : wdata_s[NIB_W-1:0];
      else
        rx_mask_ff <= ul_s ? wdata_s[DATA_W-1:NIB_W] : wdata_s[NIB_W-1:0];
    end
  end

  // channel strobes: one-cycle pulse at the start of a matched access
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      chan_rd_o    <= 1'b0;
      chan_wr_o    <= 1'b0;
      chan_sel_o   <= '0;
      chan_reg_o   <= '0;
      chan_wdata_o <= DATA_ZERO;
    end
    else
    begin
      chan_rd_o <= 1'b0;
      chan_wr_o <= 1'b0;
      if ((state_ff == ST_IDLE) && strobe_rise && block_hit && chan_access)
      begin
        chan_rd_o    <= rd_s;
        chan_wr_o    <= wr_s;
        chan_sel_o   <= NUM_USERS'(1) << phys_chan;
        chan_reg_o   <= rel_port[1:0];
        chan_wdata_o <= wdata_s;
      end
    end
  end

  // read data is held until the host drops its strobe
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      bus_rdata_o    <= DATA_ZERO;
      bus_rdata_oe_o <= 2'b00;
    end
    else if ((state_ff == ST_IDLE) && strobe_rise && block_hit && irq_access && rd_s)
    begin
      bus_rdata_o    <= nib_placed;
      bus_rdata_oe_o <= nib_oe;
    end
    else if ((state_ff == ST_WAIT) && (wcnt_ff == '0) && cap_rd_ff)
    begin
      bus_rdata_o    <= cap_sw_ff ? cfg_s : chan_rdata_i;
      bus_rdata_oe_o <= 2'b11;
    end
    else if ((state_ff == ST_HOLD) && !rd_s && !wr_s)
    begin
      bus_rdata_o    <= DATA_ZERO;
      bus_rdata_oe_o <= 2'b00;
    end
  end

  // ready is pulled low only while configured waits are counted
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      bus_rdy_o    <= 1'b0;
      bus_rdy_oe_o <= 1'b0;
    end
    else
    begin
      bus_rdy_o <= 1'b0;
      if ((state_ff == ST_IDLE) && strobe_rise && block_hit && chan_access)
        bus_rdy_oe_o <= (wait_total != '0);
      else if ((state_ff == ST_WAIT) && (wcnt_ff <= WCNT_W'(1)))
        bus_rdy_oe_o <= 1'b0;
    end
  end

  // open-collector vectored lines: only ever pulled low
  logic [NREQ-1:0]      req_gated;
  logic [NUM_LINES-1:0] line_pull;

  assign req_gated = {rx_req_i & rx_mask_ff, tx_req_i & tx_mask_ff};

  always_comb
  begin
    line_pull = '0;
    for (int k = 0; k < NREQ; k++)
    begin
      for (int j = 0; j < NUM_LINES; j++)
      begin
        if (req_gated[k] && route_s[k*NUM_LINES+j])
          line_pull[j] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      vi_o    <= '0;
      vi_oe_o <= '0;
    end
    else
    begin
      vi_o    <= '0;
      vi_oe_o <= line_pull;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      user_select_o <= USEL_RESET;
    else
      user_select_o <= usel_ff;
  end

endmodule
`default_nettype wire

// ==== sim/mup_port_decoder_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module mup_props
  import mup_pkg::*;
#(
  parameter int NU = 4,
  parameter int NL = 8
)
(
  input wire logic              core_clk_i,
  input wire logic              rst_n_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic [BASE_W-1:0] base_switch_i,
  input wire logic              board_select_low_switch_i,
  input wire logic              board_select_high_switch_i,
  input wire logic              upper_lower_switch_i,
  input wire logic              board_disable_switch_i,
  input wire logic              one_wait_jumper_i,
  input wire logic              two_wait_jumper_i,
  input wire logic              three_wait_jumper_i,
  input wire logic              channel_swap_jumper_i,
  input wire logic              bus_rdy_o,
  input wire logic              bus_rdy_oe_o,
  input wire logic [NL-1:0]     vi_o,
  input wire logic [NU-1:0]     chan_sel_o,
  input wire logic [1:0]        chan_reg_o,
  input wire logic              chan_rd_o,
  input wire logic              chan_wr_o,
  input wire logic [USEL_W-1:0] user_select_o
);
  logic [1:0] rel;
  logic [1:0] phys;
  int         nw;
  logic [7:0] wcnt_ff;
  assign rel = user_select_o[1:0];
  // parallel and middle serial trade places under the swap jumper
  assign phys = (channel_swap_jumper_i && !rel[0]) ? (rel ^ 2'h2) : rel;
  assign nw = three_wait_jumper_i ? 3 : (two_wait_jumper_i ? 2 : (one_wait_jumper_i ? 1 : 0));
  always_ff @(posedge core_clk_i)
    if (!rst_n_i)
      wcnt_ff <= 8'h00;
    else
      wcnt_ff <= bus_rdy_oe_o ? wcnt_ff + 8'h01 : 8'h00;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_acc;
    chan_rd_o || chan_wr_o;
  endsequence
  sequence s_wait_end;
    $fell(bus_rdy_oe_o);
  endsequence
  a_one_cycle_strobe:
    assert property (s_acc |=> !(chan_rd_o || chan_wr_o)) else $error("channel strobe too long");
  a_addr_in_block:
    assert property (s_acc |-> bus_addr_i[7:3] == base_switch_i && !bus_addr_i[2] && !board_disable_switch_i
      && chan_reg_o == bus_addr_i[1:0]) else $error("channel access outside block");
  a_user_match:
    assert property (s_acc |-> user_select_o[4:2] == {board_select_high_switch_i, board_select_low_switch_i,
      upper_lower_switch_i}) else $error("channel access for another board");
  a_chan_map:
    assert property (s_acc |-> chan_sel_o == (NU'(1) << phys)) else $error("wrong channel selected");
  a_wait_count:
    assert property (s_wait_end |-> wcnt_ff == WAIT_CYC * nw) else $error("wrong wait length");
  a_wait_start:
    assert property (s_acc |-> bus_rdy_oe_o == (nw != 0)) else $error("wait not started");
  a_wait_scope:
    assert property ($rose(bus_rdy_oe_o) |-> s_acc) else $error("wait outside channel access");
  a_oc_levels:
    assert property (!bus_rdy_o && vi_o == '0) else $error("open collector line driven high");
endmodule
bind mup_port_decoder mup_props #(.NU(NUM_USERS), .NL(NUM_LINES)) i_props (.*);
`default_nettype wire

// ==== sim/mup_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module mup_host
  import mup_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  input  wire logic [1:0]        rdata_oe_i,
  input  wire logic              rdy_oe_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o,
  output logic                   rd_o,
  output logic                   wr_o
);
  initial
  begin
    addr_o = 8'hFF;
    wdata_o = 8'hFF;
    rd_o = 1'b0;
    wr_o = 1'b0;
  end
  // writes hold long enough for the filtered strobe to be taken
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [9:0] q, output int cyc);
    @(posedge core_clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    rd_o = !w;
    wr_o = w;
    for (cyc = 1; cyc < 100; cyc++)
    begin
      @(posedge core_clk_i);
      #1;
      if (!rdy_oe_i && (w ? cyc >= 8 : rdata_oe_i != 2'b00))
        break;
    end
    q = {rdata_oe_i, rdata_i};
    @(posedge core_clk_i);
    #1;
    // released lines do not keep their last value
    addr_o = ~a;
    wdata_o = ~d;
    rd_o = 1'b0;
    wr_o = 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
  import mup_pkg::*;
;
  localparam logic [BASE_W-1:0] BASE = 5'h02;
  logic              core_clk_i = 1'b0;
  logic              rst_n_i, bus_rd_i, bus_wr_i, bus_rdy_o, bus_rdy_oe_o, chan_rd_o, chan_wr_o;
  logic [7:0]        bus_addr_i, bus_wdata_i, config_switch_i, chan_rdata_i, bus_rdata_o, chan_wdata_o;
  logic [BASE_W-1:0] base_switch_i;
  logic              board_select_low_switch_i, board_select_high_switch_i, upper_lower_switch_i;
  logic              board_disable_switch_i, one_wait_jumper_i, two_wait_jumper_i, three_wait_jumper_i;
  logic              channel_swap_jumper_i;
  logic [63:0]       irq_route_i;
  logic [3:0]        tx_req_i, rx_req_i, chan_sel_o, mtx, mrx;
  logic [1:0]        bus_rdata_oe_o, chan_reg_o;
  logic [7:0]        vi_o, vi_oe_o;
  logic [4:0]        user_select_o;
  logic [9:0]        q;
  int                cyc, base_cyc, num_errors = 0, n_tests = 0;
  mup_port_decoder #(.NUM_USERS(4), .NUM_LINES(8)) i_dut (.*);
  mup_host i_host (.core_clk_i(core_clk_i), .rdata_i(bus_rdata_o), .rdata_oe_i(bus_rdata_oe_o),
    .rdy_oe_i(bus_rdy_oe_o), .addr_o(bus_addr_i), .wdata_o(bus_wdata_i), .rd_o(bus_rd_i), .wr_o(bus_wr_i));
  initial
    forever #2.5 core_clk_i = ~core_clk_i;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [2:0] p, input logic [7:0] d);
    i_host.xfer(w, {BASE, p}, d, q, cyc);
  endtask
  task automatic cfg(input logic [2:0] j, input logic s, input logic dis);
    @(posedge core_clk_i);
    #1;
    {three_wait_jumper_i, two_wait_jumper_i, one_wait_jumper_i} = j;
    channel_swap_jumper_i = s;
    board_disable_switch_i = dis;
    repeat (6) @(posedge core_clk_i);
    #1;
  endtask
  task automatic probe(input logic [4:0] us, input logic [7:0] a, input logic [1:0] eoe);
    acc(1'b1, PORT_USER_SEL, {3'b000, us});
    i_host.xfer(1'b0, a, 8'h00, q, cyc);
    check("enable", q[9:8], eoe);
  endtask
  function automatic logic [7:0] exp_vi();
    logic [7:0] v;
    logic [7:0] req;
    v = 8'h00;
    req = {rx_req_i & mrx, tx_req_i & mtx};
    for (int k = 0; k < 8; k++)
      for (int j = 0; j < 8; j++)
        v[j] = v[j] | (req[k] & irq_route_i[k*8+j]);
    return v;
  endfunction
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    $display("watchdog expired");
    final_report();
  end
  initial
  begin
    logic [1:0] ph;
    logic [7:0] d;
    void'($urandom(32'h0519));
    rst_n_i = 1'b0;
    base_switch_i = BASE;
    {board_select_high_switch_i, board_select_low_switch_i, upper_lower_switch_i} = 3'b001;
    {three_wait_jumper_i, two_wait_jumper_i, one_wait_jumper_i} = 3'b000;
    channel_swap_jumper_i = 1'b0;
    board_disable_switch_i = 1'b0;
    config_switch_i = 8'($urandom);
    chan_rdata_i = 8'($urandom);
    irq_route_i = {$urandom, $urandom};
    tx_req_i = 4'h0;
    rx_req_i = 4'h0;
    mtx = 4'h0;
    mrx = 4'h0;
    repeat (10) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      cfg(3'b000, s[0], 1'b0);
      for (int u = 0; u < 4; u++)
      begin
        acc(1'b1, PORT_USER_SEL, {6'h01, u[1:0]});
        check("user select", user_select_o, {3'b001, u[1:0]});
        ph = (s[0] && !u[0]) ? (u[1:0] ^ 2'h2) : u[1:0];
        for (int p = 0; p < 4; p++)
        begin
          chan_rdata_i = 8'($urandom);
          acc(1'b0, p[2:0], 8'h00);
          check("read enable", q[9:8], 2'b11);
          check("read data", q[7:0], (p == 0 && ph == CH_PARALLEL) ? config_switch_i : chan_rdata_i);
          check("channel", chan_sel_o, 4'h1 << ph);
          check("register", chan_reg_o, p);
          d = 8'($urandom);
          acc(1'b1, p[2:0], d);
          check("write data", chan_wdata_o, d);
        end
      end
    end
    $display("test decode done");
    for (int j = 0; j < 8; j++)
    begin
      cfg(j[2:0], 1'b0, 1'b0);
      acc(1'b0, PORT_CHAN_DATA, 8'h00);
      if (j == 0)
        base_cyc = cyc;
      check("wait cycles", cyc - base_cyc, WAIT_CYC * (j > 3 ? 3 : (j > 1 ? 2 : j)));
      acc(1'b0, PORT_TX_IRQ, 8'h00);
      // status ports answer at the take edge, one ahead of a no-wait channel read
      check("irq port cycles", cyc, base_cyc - 1);
    end
    $display("test wait states done");
    cfg(3'b001, 1'b0, 1'b0);
    probe(5'h05, {BASE, PORT_UNUSED}, 2'b00);
    probe(5'h05, {BASE, PORT_USER_SEL}, 2'b00);
    probe(5'h05, {BASE + 5'h01, PORT_CHAN_DATA}, 2'b00);
    probe(5'h01, {BASE, PORT_CHAN_DATA}, 2'b00);
    probe(5'h01, {BASE, PORT_RX_IRQ}, 2'b10);
    probe(5'h19, {BASE, PORT_TX_IRQ}, 2'b00);
    upper_lower_switch_i = 1'b0;
    probe(5'h00, {BASE, PORT_RX_IRQ}, 2'b01);
    upper_lower_switch_i = 1'b1;
    // matching user first, so only the disable switch can refuse
    acc(1'b1, PORT_USER_SEL, 8'h05);
    cfg(3'b000, 1'b0, 1'b1);
    i_host.xfer(1'b0, {BASE, PORT_TX_IRQ}, 8'h00, q, cyc);
    check("disabled board", q[9:8], 2'b00);
    cfg(3'b000, 1'b0, 1'b0);
    $display("test refusals done");
    acc(1'b1, PORT_USER_SEL, 8'h05);
    for (int i = 0; i < 8; i++)
    begin
      mtx = 4'($urandom);
      mrx = 4'($urandom);
      tx_req_i = 4'($urandom);
      rx_req_i = 4'($urandom);
      acc(1'b1, PORT_TX_IRQ, {mtx, ~mtx});
      acc(1'b1, PORT_RX_IRQ, {mrx, ~mrx});
      acc(1'b0, PORT_TX_IRQ, 8'h00);
      check("tx status", {q[9:8], q[7:4]}, {2'b10, tx_req_i});
      acc(1'b0, PORT_RX_IRQ, 8'h00);
      check("rx status", {q[9:8], q[7:4]}, {2'b10, rx_req_i});
      check("vectored lines", vi_oe_o, exp_vi());
    end
    tx_req_i = 4'hF;
    rx_req_i = 4'hF;
    rst_n_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    check("lines after reset", vi_oe_o, 8'h00);
    $display("test interrupts done");
    final_report();
  end
endmodule
`default_nettype wire
